// file: core/sxio_pkg.sv
package sxio_pkg;
   // Port and bus geometry
   localparam int NUM_PORTS = 16;
   localparam int GROUP_SIZE = 4;
   localparam int NUM_GROUPS = 4;
   localparam int ADDR_W = 4;
   localparam int CMD_W = 7;
   localparam int DATA_W = 32;
   localparam int MODE_W = 16;
   // Bus addresses
   localparam logic [3:0] ADDR_MAX = 4'hE;
   localparam logic [3:0] ADDR_BCAST = 4'hF;
   // Command code ranges
   localparam logic [6:0] CMD_CNT_FIRST = 7'h01;
   localparam logic [6:0] CMD_CNT_LAST = 7'h10;
   localparam logic [6:0] CMD_GCNT_FIRST = 7'h11;
   localparam logic [6:0] CMD_GCNT_LAST = 7'h17;
   localparam logic [6:0] CMD_FREQ_FIRST = 7'h18;
   localparam logic [6:0] CMD_FREQ_LAST = 7'h27;
   localparam logic [6:0] CMD_DUTY_FIRST = 7'h2F;
   localparam logic [6:0] CMD_DUTY_LAST = 7'h3E;
   localparam logic [6:0] CMD_READ_LAST = 7'h45;
   localparam logic [6:0] CMD_DEB_FIRST = 7'h46;
   localparam logic [6:0] CMD_DEB_LAST = 7'h55;
   localparam logic [6:0] CMD_RD_A = 7'h5B;
   localparam logic [6:0] CMD_RD_B = 7'h5C;
   localparam logic [6:0] CMD_WR_FIRST = 7'h5D;
   localparam logic [6:0] CMD_WR_LAST = 7'h62;
   localparam logic [6:0] CMD_RD_C = 7'h63;
   // Codes of my own: 96 sets output levels, 97 sets edge interrupt enables
   localparam logic [6:0] CMD_SET_OUT = 7'h60;
   localparam logic [6:0] CMD_SET_IRQ = 7'h61;
   // Mode nibble encoding per four-port group: 0 input, 1 output
   localparam logic [3:0] MODE_INPUT = 4'h0;
   localparam logic [3:0] MODE_OUTPUT = 4'h1;
   // Measurement gate, 1 s at 125 MHz
   localparam int CLK_HZ = 125_000_000;
   localparam int GATE_MS = 1000;
   localparam int GATE_CYC = CLK_HZ / 1000 * GATE_MS;
   localparam logic [15:0] DEB_RESET = 16'h0000;
   // Host retry limit
   localparam int MAX_TRIES = 4;
   localparam int RESP_TIMEOUT = 64;

   // Zero-based port index encoded by a command within a 16-code range
   function automatic logic [3:0] sxio_port_of(input logic [6:0] cmd, input logic [6:0] first);
      logic [6:0] d;
      d = cmd - first;
      return d[3:0];
   endfunction

   function automatic logic sxio_in_range(input logic [6:0] c, input logic [6:0] lo,
                                          input logic [6:0] hi);
      return (c >= lo) && (c <= hi);
   endfunction
endpackage

// file: core/sxio_bus_if.sv
`timescale 1ns/1ps
// Synchronous expansion bus between host and module
interface sxio_bus_if;
   import sxio_pkg::*;
   logic req;
   logic [ADDR_W-1:0] addr;
   logic [CMD_W-1:0] cmd;
   logic [DATA_W-1:0] wdata;
   logic [4*MODE_W/4-1:0] mode;
   logic ack;
   logic nak;
   logic rvalid;
   logic [DATA_W-1:0] rdata;
   logic irq;

   modport host (output req, output addr, output cmd, output wdata, output mode,
                 input ack, input nak, input rvalid, input rdata, input irq);
   modport device (input req, input addr, input cmd, input wdata, input mode,
                   output ack, output nak, output rvalid, output rdata, output irq);
endinterface

// file: core/sxio_device.sv
`timescale 1ns/1ps
// Behaviour
// - Each of 16 ports is input or output
// - Inputs report level, counts, frequency, duty
// - Input change can raise host interrupt
// - Output ports drive host-commanded level
// - Host status zero on success, counts failures
// - Respond only at address 0-14; 15 broadcast
// - Host steps address by one per module
// - Codes 1-16 return one port count
// - Read codes return data, write codes take
// - Mode carried as four four-port groups
// - Codes 17-23 return group counts
// - Codes 24-39 return port frequency
// - Codes 47-62 return port duty cycle
// - Codes 70-85 set port debounce time
module sxio_device
   import sxio_pkg::*;
#(
   parameter int GATE_CYCLES = GATE_CYC
) (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] module_bus_address,
   sxio_bus_if.device bus,
   input wire logic [NUM_PORTS-1:0] port_in,
   output logic [NUM_PORTS-1:0] port_out,
   output logic [NUM_PORTS-1:0] port_oe_n,
   output logic trigger_seen
);
   typedef enum logic [1:0] {SXIO_IDLE, SXIO_GROUP} sxio_state_t;

   logic [NUM_PORTS-1:0] is_output;
   logic [NUM_PORTS-1:0] out_level;
   logic [NUM_PORTS-1:0] irq_en;
   logic [NUM_PORTS-1:0] deb_level;
   logic [NUM_PORTS-1:0] prev_level;
   logic [DATA_W-1:0] count [NUM_PORTS];
   logic [DATA_W-1:0] freq [NUM_PORTS];
   logic [DATA_W-1:0] duty [NUM_PORTS];
   logic [DATA_W-1:0] edges_gate [NUM_PORTS];
   logic [DATA_W-1:0] high_gate [NUM_PORTS];
   logic [15:0] deb_time [NUM_PORTS];
   logic [15:0] deb_cnt [NUM_PORTS];
   logic [31:0] gate_cnt;
   logic irq_pend;
   sxio_state_t state;
   logic [3:0] grp_idx;
   logic [4:0] grp_left;

   // Address and command decode
   wire addr_ok = (module_bus_address <= ADDR_MAX);
   wire hit = bus.req && addr_ok && (bus.addr == module_bus_address);
   wire bcast = bus.req && (bus.addr == ADDR_BCAST);
   wire [6:0] c = bus.cmd;
   wire is_cnt = sxio_in_range(c, CMD_CNT_FIRST, CMD_CNT_LAST);
   wire is_gcnt = sxio_in_range(c, CMD_GCNT_FIRST, CMD_GCNT_LAST);
   wire is_freq = sxio_in_range(c, CMD_FREQ_FIRST, CMD_FREQ_LAST);
   wire is_duty = sxio_in_range(c, CMD_DUTY_FIRST, CMD_DUTY_LAST);
   wire is_deb = sxio_in_range(c, CMD_DEB_FIRST, CMD_DEB_LAST);
   wire is_read = sxio_in_range(c, CMD_CNT_FIRST, CMD_READ_LAST)
                  || c == CMD_RD_A || c == CMD_RD_B || c == CMD_RD_C;
   wire is_write = is_deb || sxio_in_range(c, CMD_WR_FIRST, CMD_WR_LAST);
   wire gate_end = (gate_cnt == 32'(GATE_CYCLES - 1));
   wire [NUM_PORTS-1:0] rise = deb_level & ~prev_level;
   wire [NUM_PORTS-1:0] change = (deb_level ^ prev_level) & ~is_output;

   // Group table: first port and length for codes 17..23
   wire [2:0] gsel = 3'(c - CMD_GCNT_FIRST);
   wire [3:0] g_first = (gsel < 3'h4) ? {gsel[1:0], 2'h0} : (gsel == 3'h5) ? 4'h8 : 4'h0;
   wire [4:0] g_len = (gsel < 3'h4) ? 5'h04 : (gsel == 3'h6) ? 5'h10 : 5'h08;

   // Single-port read mux
   wire [DATA_W-1:0] single_val =
      is_cnt ? count[sxio_port_of(c, CMD_CNT_FIRST)] :
      is_freq ? freq[sxio_port_of(c, CMD_FREQ_FIRST)] :
      is_duty ? duty[sxio_port_of(c, CMD_DUTY_FIRST)] :
      {{(DATA_W-NUM_PORTS){1'b0}}, deb_level}; // Other read codes give levels

   // Direction from the four mode groups, one nibble per port group
   genvar g;
   generate
      for (g = 0; g < NUM_PORTS; g++) begin : gen_port
         wire [3:0] nib = bus.mode[4*(g/GROUP_SIZE) +: 4];
         // Debounce: level accepted after deb_time+1 stable cycles
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               deb_level[g] <= 1'b0;
               deb_cnt[g] <= 16'h0000;
            end else if (clk_en) begin
               if (port_in[g] == deb_level[g]) begin
                  deb_cnt[g] <= 16'h0000;
               end else if (deb_cnt[g] >= deb_time[g]) begin
                  deb_level[g] <= port_in[g];
                  deb_cnt[g] <= 16'h0000;
               end else begin
                  deb_cnt[g] <= deb_cnt[g] + 16'h0001;
               end
            end
         end
         // Counting and gated frequency and duty measurement
         always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
               count[g] <= '0;
               freq[g] <= '0;
               duty[g] <= '0;
               edges_gate[g] <= '0;
               high_gate[g] <= '0;
               deb_time[g] <= DEB_RESET;
               is_output[g] <= 1'b0;
            end else if (clk_en) begin
               if (hit) begin
                  is_output[g] <= (nib == MODE_OUTPUT);
               end
               if (hit && is_deb && sxio_port_of(c, CMD_DEB_FIRST) == 4'(g)) begin
                  deb_time[g] <= bus.wdata[15:0];
               end
               if (rise[g] && !is_output[g]) begin
                  count[g] <= count[g] + 1'b1;
               end
               if (gate_end) begin
                  freq[g] <= edges_gate[g]; // Edges per 1 s gate is Hz
                  duty[g] <= high_gate[g] / 32'(GATE_CYCLES / 1000); // Per mille
                  edges_gate[g] <= '0;
                  high_gate[g] <= '0;
               end else begin
                  edges_gate[g] <= edges_gate[g] + DATA_W'(rise[g]);
                  high_gate[g] <= high_gate[g] + DATA_W'(deb_level[g]);
               end
            end
         end
      end
   endgenerate

   // Gate timer and previous level for edge and change detection
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         gate_cnt <= '0;
         prev_level <= '0;
      end else if (clk_en) begin
         gate_cnt <= gate_end ? '0 : gate_cnt + 1'b1;
         prev_level <= deb_level;
      end
   end

   // Outputs, interrupt and command answers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         out_level <= '0;
         irq_en <= '0;
         irq_pend <= 1'b0;
         port_out <= '0;
         port_oe_n <= '1;
         bus.ack <= 1'b0;
         bus.nak <= 1'b0;
         bus.rvalid <= 1'b0;
         bus.rdata <= '0;
         bus.irq <= 1'b0;
         trigger_seen <= 1'b0;
         state <= SXIO_IDLE;
         grp_idx <= '0;
         grp_left <= '0;
      end else if (clk_en) begin
         bus.ack <= 1'b0;
         bus.nak <= 1'b0;
         bus.rvalid <= 1'b0;
         trigger_seen <= bcast;
         port_out <= out_level & is_output;
         port_oe_n <= ~is_output;
         // Set wins over a same-cycle host clear
         if (|(change & irq_en)) begin
            irq_pend <= 1'b1;
         end else if (hit && is_read) begin
            irq_pend <= 1'b0;
         end
         bus.irq <= irq_pend;
         unique case (state)
            SXIO_IDLE: begin
               if (hit) begin
                  bus.ack <= is_read || is_write;
                  bus.nak <= !(is_read || is_write);
                  if (is_write && c == CMD_SET_OUT) begin
                     out_level <= bus.wdata[NUM_PORTS-1:0];
                  end
                  if (is_write && c == CMD_SET_IRQ) begin
                     irq_en <= bus.wdata[NUM_PORTS-1:0];
                  end
                  if (is_gcnt) begin
                     state <= SXIO_GROUP; // Streams one word per cycle
                     grp_idx <= g_first;
                     grp_left <= g_len;
                  end else if (is_read) begin
                     bus.rvalid <= 1'b1;
                     bus.rdata <= single_val;
                  end
               end
            end
            SXIO_GROUP: begin
               bus.rvalid <= 1'b1;
               bus.rdata <= count[grp_idx];
               grp_idx <= grp_idx + 4'h1;
               grp_left <= grp_left - 5'h01;
               if (grp_left == 5'h01) begin
                  state <= SXIO_IDLE;
               end
            end
         endcase
      end
   end
endmodule

// file: core/sxio_host.sv
`timescale 1ns/1ps
module sxio_host
   import sxio_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic start,
   input wire logic [ADDR_W-1:0] base_addr,
   input wire logic [3:0] reps,
   input wire logic [CMD_W-1:0] command,
   input wire logic [DATA_W-1:0] source,
   input wire logic [MODE_W-1:0] mode_all,
   sxio_bus_if.host bus,
   output logic busy,
   output logic done,
   output logic [7:0] status,
   output logic dvalid,
   output logic [DATA_W-1:0] dest,
   output logic irq_seen
);
   typedef enum logic [1:0] {SXH_IDLE, SXH_WAIT, SXH_DATA} sxh_state_t;
   sxh_state_t state;
   logic [ADDR_W-1:0] cur_addr;
   logic [3:0] left;
   logic [6:0] tmo;
   logic [4:0] words;
   wire is_gcnt = sxio_in_range(command, CMD_GCNT_FIRST, CMD_GCNT_LAST);
   wire [2:0] gsel = 3'(command - CMD_GCNT_FIRST);
   wire [4:0] nwords = !is_gcnt ? 5'h01 : (gsel < 3'h4) ? 5'h04 : (gsel == 3'h6) ? 5'h10 : 5'h08;
   wire is_read = sxio_in_range(command, CMD_CNT_FIRST, CMD_READ_LAST)
                  || command == CMD_RD_A || command == CMD_RD_B || command == CMD_RD_C;

   // Single-command sequencer with retry and address stepping
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= SXH_IDLE;
         bus.req <= 1'b0;
         bus.addr <= '0;
         bus.cmd <= '0;
         bus.wdata <= '0;
         bus.mode <= '0;
         cur_addr <= '0;
         left <= '0;
         tmo <= '0;
         words <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         status <= '0;
         dvalid <= 1'b0;
         dest <= '0;
         irq_seen <= 1'b0;
      end else if (clk_en) begin
         done <= 1'b0;
         dvalid <= 1'b0;
         bus.req <= 1'b0;
         irq_seen <= bus.irq;
         unique case (state)
            SXH_IDLE: begin
               if (start) begin
                  busy <= 1'b1;
                  status <= '0;
                  cur_addr <= base_addr;
                  left <= reps;
                  bus.req <= 1'b1;
                  bus.addr <= base_addr;
                  bus.cmd <= command;
                  bus.wdata <= source;
                  bus.mode <= mode_all;
                  tmo <= '0;
                  state <= SXH_WAIT;
               end
            end
            SXH_WAIT: begin
               tmo <= tmo + 7'h01;
               if (bus.ack && is_read && is_gcnt) begin
                  words <= nwords;
                  state <= SXH_DATA;
               end else if (bus.ack || bus.nak || tmo == 7'(RESP_TIMEOUT)) begin
                  // A single read's word rides with its acknowledge and stands one cycle
                  if (bus.ack && bus.rvalid) begin
                     dvalid <= 1'b1;
                     dest <= bus.rdata;
                  end
                  if (!bus.ack) begin
                     status <= status + 8'h01;
                  end
                  if (bus.ack) begin
                     status <= '0;
                  end
                  if (!bus.ack && status < 8'(MAX_TRIES - 1)) begin
                     bus.req <= 1'b1; // Retry same module
                     tmo <= '0;
                  end else if (left != 4'h0 && cur_addr < ADDR_MAX) begin
                     left <= left - 4'h1;
                     cur_addr <= cur_addr + 4'h1;
                     bus.addr <= cur_addr + 4'h1;
                     bus.req <= 1'b1;
                     tmo <= '0;
                  end else begin
                     busy <= 1'b0;
                     done <= 1'b1;
                     state <= SXH_IDLE;
                  end
               end
            end
            SXH_DATA: begin
               if (bus.rvalid) begin
                  dvalid <= 1'b1;
                  dest <= bus.rdata;
                  words <= words - 5'h01;
                  if (words == 5'h01) begin
                     status <= '0;
                     if (left != 4'h0 && cur_addr < ADDR_MAX) begin
                        left <= left - 4'h1;
                        cur_addr <= cur_addr + 4'h1;
                        bus.addr <= cur_addr + 4'h1;
                        bus.req <= 1'b1;
                        tmo <= '0;
                        state <= SXH_WAIT;
                     end else begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= SXH_IDLE;
                     end
                  end
               end
            end
            default: state <= SXH_IDLE;
         endcase
      end
   end
endmodule

// file: testbench/sxio_checker.sv
`timescale 1ns/1ps
// Watches the bus between host and module from the module's side
module sxio_checker
   import sxio_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [ADDR_W-1:0] module_bus_address,
   input wire logic req,
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [CMD_W-1:0] cmd,
   input wire logic ack,
   input wire logic nak,
   input wire logic rvalid
);
   // A request this module must take; address 15 never qualifies as its own
   logic hit;
   assign hit = req && clk_en && (addr == module_bus_address) && (module_bus_address <= ADDR_MAX);

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   chk_hit_answered: assert property (hit |=> (ack || nak))
      else $error("taken request got no answer");
   chk_miss_silent: assert property (req && addr != module_bus_address |=> !ack && !nak)
      else $error("answer to a foreign address");
   chk_bcast_silent: assert property (req && addr == ADDR_BCAST |=> !(ack || nak))
      else $error("answer to the broadcast address");
   chk_count_read: assert property (hit && cmd >= CMD_CNT_FIRST && cmd <= CMD_CNT_LAST
      |=> ack && rvalid)
      else $error("single count read without data");
   chk_group_four: assert property (hit && cmd == CMD_GCNT_FIRST
      |=> ack ##1 rvalid [*4] ##1 !rvalid)
      else $error("group of four word count wrong");
   chk_group_all: assert property (hit && cmd == CMD_GCNT_LAST
      |=> ack ##1 rvalid [*8] ##1 rvalid [*8] ##1 !rvalid)
      else $error("group of sixteen word count wrong");
   chk_write_nodata: assert property (hit && cmd >= CMD_DEB_FIRST && cmd <= CMD_DEB_LAST
      |=> ack && !rvalid)
      else $error("write code returned data");
   chk_undef_nak: assert property (hit && cmd > CMD_DEB_LAST && cmd < CMD_RD_A
      |=> nak && !ack)
      else $error("undefined code not refused");
   chk_answer_once: assert property ((ack || nak) |=> !(ack || nak))
      else $error("answer longer than one cycle");
endmodule

// file: testbench/sixteen_port_io_expander_bench.sv
`timescale 1ns/1ps
module sixteen_port_io_expander_bench
   import sxio_pkg::*;
;
   logic core_clk, rst_n, clk_en, start;
   logic [3:0] base_addr, reps, mba;
   logic [6:0] command;
   logic [31:0] source, dest;
   logic [15:0] mode_all, port_in, port_out, port_oe_n;
   logic [7:0] status;
   logic busy, done, dvalid, irq_seen, trigger_seen;
   logic [31:0] words[$];
   int n_mismatch = 0;
   int comparisons = 0;
   int trig_cnt = 0;
   int k;

   sxio_bus_if sxio_bus_if_inst();
   sxio_host sxio_host_inst(.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
      .start(start), .base_addr(base_addr), .reps(reps), .command(command),
      .source(source), .mode_all(mode_all), .bus(sxio_bus_if_inst), .busy(busy),
      .done(done), .status(status), .dvalid(dvalid), .dest(dest), .irq_seen(irq_seen));
   // Short gate keeps measurement windows affordable in simulation
   sxio_device #(.GATE_CYCLES(2000)) sxio_device_inst(.core_clk(core_clk), .rst_n(rst_n),
      .clk_en(clk_en), .module_bus_address(mba), .bus(sxio_bus_if_inst), .port_in(port_in),
      .port_out(port_out), .port_oe_n(port_oe_n), .trigger_seen(trigger_seen));
   sxio_checker sxio_checker_inst(.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
      .module_bus_address(mba), .req(sxio_bus_if_inst.req), .addr(sxio_bus_if_inst.addr),
      .cmd(sxio_bus_if_inst.cmd), .ack(sxio_bus_if_inst.ack), .nak(sxio_bus_if_inst.nak),
      .rvalid(sxio_bus_if_inst.rvalid));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // Collect every word the host hands over, and count trigger pulses
   always @(posedge core_clk) begin
      if (dvalid === 1'b1) words.push_back(dest);
      if (trigger_seen === 1'b1) trig_cnt++;
   end

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp_v);
      comparisons++;
      if (seen !== exp_v) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp_v, seen);
      end
   endtask

   task automatic test_done();
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // One host operation; waits for done under a bound
   task automatic run(input logic [3:0] a, input logic [6:0] c, input logic [31:0] s);
      int i;
      words.delete();
      @(posedge core_clk);
      base_addr <= a;
      command <= c;
      source <= s;
      start <= 1'b1;
      @(posedge core_clk);
      start <= 1'b0;
      for (i = 0; i < 2000 && done !== 1'b1; i++) @(posedge core_clk);
      if (i == 2000) begin
         n_mismatch++;
         test_done();
      end else begin
         @(posedge core_clk);
      end
   endtask

   // Clean pulses; low time outlasts the longest debounce used here
   task automatic pulses(input int p, input int n, input int hi);
      repeat (n) begin
         @(posedge core_clk);
         port_in[p] <= 1'b1;
         repeat (hi) @(posedge core_clk);
         port_in[p] <= 1'b0;
         repeat (16) @(posedge core_clk);
      end
   endtask

   initial begin
      rst_n = 1'b0;
      clk_en = 1'b1;
      start = 1'b0;
      base_addr = 4'h0;
      reps = 4'h0;
      mba = 4'h5;
      command = 7'h00;
      source = 32'h0;
      mode_all = 16'h0000;
      port_in = 16'h0000;
      repeat (8) @(posedge core_clk);
      rst_n <= 1'b1;
      pulses(2, 3, 4);
      pulses(15, 5, 4);
      run(4'h5, 7'h03, 32'h0);
      check("status", {24'h0, status}, 32'h0);
      check("busy", {31'h0, busy}, 32'h0);
      check("count3", words[0], 32'h3);
      run(4'h5, 7'h10, 32'h0);
      check("count16", words[0], 32'h5);
      run(4'h5, 7'h03, 32'h0);
      check("count3 again", words[0], 32'h3);
      run(4'h5, 7'h11, 32'h0);
      check("group size", words.size(), 32'h4);
      for (k = 0; k < 4; k++) check("group1", words[k], (k == 2) ? 32'h3 : 32'h0);
      run(4'h5, 7'h17, 32'h0);
      check("all size", words.size(), 32'h10);
      for (k = 0; k < 16; k++) begin
         check("all", words[k], (k == 2) ? 32'h3 : (k == 15) ? 32'h5 : 32'h0);
      end
      run(4'h5, 7'h19, 32'h0);
      check("freq idle", words[0], 32'h0);
      run(4'h5, 7'h30, 32'h0);
      check("duty idle", words[0], 32'h0);
      run(4'h5, 7'h46, 32'hA);
      check("deb status", {24'h0, status}, 32'h0);
      pulses(0, 1, 3);
      pulses(0, 1, 20);
      run(4'h5, 7'h01, 32'h0);
      check("debounced", words[0], 32'h1);
      run(4'h6, 7'h03, 32'h0);
      check("foreign", {24'h0, status}, MAX_TRIES);
      // Empty slot at 4 times out, then the host steps on to this module
      reps <= 4'h1;
      run(4'h4, 7'h03, 32'h0);
      check("stepped", words[0], 32'h3);
      check("stepped status", {24'h0, status}, 32'h0);
      reps <= 4'h0;
      // Nobody answers a broadcast, so every retry makes one more trigger
      run(4'hF, 7'h03, 32'h0);
      check("trigger", trig_cnt, 32'(MAX_TRIES));
      run(4'h5, 7'h56, 32'h0);
      check("undefined", {31'h0, status != 8'h00}, 32'h1);
      mode_all <= 16'h1001;
      run(4'h5, 7'h60, 32'h0000A5C3);
      check("oe_n", {16'h0, port_oe_n}, 32'h00000FF0);
      check("out", {16'h0, port_out & 16'hF00F}, 32'h0000A003);
      mode_all <= 16'h0000;
      run(4'h5, 7'h61, 32'h10);
      pulses(4, 1, 4);
      for (k = 0; k < 200 && irq_seen !== 1'b1; k++) @(posedge core_clk);
      check("irq", {31'h0, irq_seen}, 32'h1);
      run(4'h5, 7'h01, 32'h0);
      check("irq cleared", {31'h0, irq_seen}, 32'h0);
      test_done();
   end
endmodule
